// *** etw_bus_asserts.sv ***
/*
  checker for the two-wire bus between host and eeprom client.
  assumes it sees the resolved wires and the client's drive, on clock.
*/
`include "etw_defines.svh"
module etw_bus_asserts (
  input wire logic clock,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n
);
  logic scl_q, sda_q, first, rd, mism, nackf;
  logic [3:0] bc;
  logic [4:0] lowc;
  logic [7:0] sh;
  wire start = scl && scl_q && sda_q && !sda;
  wire stop = scl && scl_q && !sda_q && sda;
  wire rise = scl && !scl_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////
  // wire history, idle high
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // cycles since scl went low, saturating
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) lowc <= 5'h00;
    else lowc <= scl ? 5'h00 : (lowc == 5'h1f ? lowc : lowc + 5'h01);
  end
  // bit count within byte, control byte decode, host nack
  // synchronous clear: reset, start and stop all restart the count
  always_ff @(posedge clock) begin
    if (!nrst || start || stop) begin
      bc <= 4'h0;
      sh <= 8'h00;
      first <= 1'b1;
      rd <= 1'b0;
      mism <= 1'b0;
      nackf <= 1'b0;
    end else if (rise) begin
      bc <= (bc == 4'h9) ? 4'h1 : bc + 4'h1;
      sh <= {sh[6:0], sda};
      if (first && bc == 4'h7) begin
        rd <= sda;
        mism <= (sh[6:3] != `ETW_DEV_CODE);
      end
      if (bc == 4'h8) first <= 1'b0;
      if (bc == 4'h8 && rd && !first && sda) nackf <= 1'b1;
    end
  end
  //////////////////////////////////////////////////
  sequence s_start;
    scl && $past(scl) && $past(sda) && !sda;
  endsequence
  sequence s_stop;
    scl && $past(scl) && !$past(sda) && sda;
  endsequence
  property p_dev_od;
    !dev_sda_oe_n |-> !dev_sda_o;
  endproperty
  a_dev_od: assert property (p_dev_od) else $error("client drove sda high");
  property p_hold_high;
    scl && $past(scl) |-> $stable(dev_sda_oe_n);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("client sda moved in scl high");
  property p_tx_delay;
    $changed(dev_sda_oe_n) |-> !scl && lowc >= 5'h0f;
  endproperty
  a_tx_delay: assert property (p_tx_delay) else $error("client sda moved too soon after scl fall");
  property p_start_idle;
    s_start |-> $past(scl, 2) && $past(sda, 2);
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("start not from high lines");
  property p_stop_quiet;
    s_stop |=> dev_sda_oe_n [*8];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("client pulled sda after stop");
  property p_mismatch_quiet;
    mism |-> dev_sda_oe_n;
  endproperty
  a_mismatch_quiet: assert property (p_mismatch_quiet) else $error("client answered wrong code");
  property p_ack_slot;
    scl && scl_q && !dev_sda_oe_n && !(rd && !first) |-> bc == 4'h9;
  endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("client low outside ninth pulse");
  property p_nack_release;
    nackf |-> dev_sda_oe_n;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("client sent after host nack");
endmodule // etw_bus_asserts

// *** etw_bus_if.sv ***
/*
  two-wire bus between host and eeprom client.
  assumes pull-ups: each wire is high unless an end pulls it low.
*/
interface etw_bus_if;
  logic scl_o;
  logic scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;
  // wired-and with pull-ups
  assign scl = scl_oe_n ? 1'b1 : scl_o;
  assign sda = (host_sda_oe_n ? 1'b1 : host_sda_o) & (dev_sda_oe_n ? 1'b1 : dev_sda_o);
  modport host (output scl_o, output scl_oe_n, output host_sda_o, output host_sda_oe_n, input scl, input sda);
  modport device (output dev_sda_o, output dev_sda_oe_n, input scl, input sda);
endinterface // etw_bus_if

// *** etw_client.sv ***
/*
  two-wire eeprom client: start/stop detect, byte shift, ack, page buffer,
  self-timed write, 2 KiB array in flip-flops.
  assumes scl and sda come from another domain; sampled on clock.
*/
`include "etw_defines.svh"
// Overview of operation
// - sda fall with scl high is start
// - sda rise with scl high is stop
// - sda changes only while scl low
// - host starts only on idle bus; this host also sends repeated starts mid-transfer
// - one scl pulse per stable bit
// - receiver acks each byte on ninth pulse
// - ack low stable across scl high
// - no ack during programming cycle
// - host nacks final read byte
// - on host nack release sda, stop
// - keep only last sixteen written bytes
// - programming cycle ends within 5 ms
// - sda change delayed 300 ns after fall
// - protect low allows full access
// - protect high blocks all writes
// - spare address pins are ignored
// - sda open-drain only, never high
// - host makes clock and framing
// - control byte code, block bits, rw
// - rw one reads, zero writes
// - page write wraps low four bits
// - stop after write starts programming
module etw_client #(
  parameter int WRITE_CYC = `ETW_WRITE_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  etw_bus_if.device bus,
  input wire logic write_protect,
  input wire logic spare_address_pin_0,
  input wire logic spare_address_pin_1,
  input wire logic spare_address_pin_2,
  output logic busy
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic scl_d;
  logic sda_d;
  logic [1:0] wp_s;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      wp_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], bus.scl};
      sda_s <= {sda_s[0], bus.sda};
      wp_s <= {wp_s[0], write_protect};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_s[1] && !scl_d;
  assign scl_fall = !scl_s[1] && scl_d;
  assign start_det = scl_s[1] && scl_d && sda_d && !sda_s[1];
  assign stop_det = scl_s[1] && scl_d && !sda_d && sda_s[1];
  // spare pins deliberately unused
  logic spare_unused;
  assign spare_unused = spare_address_pin_0 ^ spare_address_pin_1 ^ spare_address_pin_2;

  ////////////////////////////////////////////////////////////////////////
  // array, page buffer, state
  logic [7:0] mem [2**`ETW_ADDR_W];
  logic [7:0] page [`ETW_PAGE_BYTES];
  logic [`ETW_PAGE_BYTES-1:0] page_vld;
  logic [`ETW_ADDR_W-1:0] ptr;
  logic [`ETW_ADDR_W-1:0] page_base;
  etw_pkg::etw_dev_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic ack_phase;
  logic drive_low;
  logic pending_low;
  logic [4:0] dly;
  logic wrote;
  logic [31:0] wc_cnt;
  logic [4:0] flush_idx;

  // 11-bit address from block bits and word byte
  function automatic logic [`ETW_ADDR_W-1:0] etw_addr(input logic [2:0] blk, input logic [7:0] word);
    etw_addr = {blk, word};
  endfunction

  // protocol engine; counts received bits on scl rise, acts on scl fall
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= etw_pkg::ETW_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      ack_phase <= 1'b0;
      pending_low <= 1'b0;
      ptr <= '0;
      page_base <= '0;
      page_vld <= '0;
      wrote <= 1'b0;
    end else if (start_det) begin
      state <= etw_pkg::ETW_CTRL;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      pending_low <= 1'b0;
      // a repeated start abandons unlaunched page data
      wrote <= 1'b0;
    end else if (stop_det) begin
      state <= etw_pkg::ETW_IDLE;
      pending_low <= 1'b0;
      ack_phase <= 1'b0;
      wrote <= 1'b0;
    end else if (state != etw_pkg::ETW_IDLE && state != etw_pkg::ETW_SKIP) begin
      if (scl_rise) begin
        if (ack_phase) begin
          // master ack sample during read
          if (state == etw_pkg::ETW_RDATA && sda_s[1]) begin
            state <= etw_pkg::ETW_SKIP;
          end
        end else if (state != etw_pkg::ETW_RDATA) begin
          shift <= {shift[6:0], sda_s[1]};
          bit_cnt <= bit_cnt + 4'h1;
        end
      end else if (scl_fall) begin
        if (ack_phase) begin
          ack_phase <= 1'b0;
          bit_cnt <= 4'h0;
          if (state == etw_pkg::ETW_RDATA) begin
            shift <= mem[ptr];
            ptr <= ptr + 1'b1;
            pending_low <= !mem[ptr][7];
          end else begin
            pending_low <= 1'b0;
          end
        end else if (state == etw_pkg::ETW_RDATA) begin
          // next read bit out
          if (bit_cnt == 4'h7) begin
            ack_phase <= 1'b1;
            pending_low <= 1'b0;
          end else begin
            pending_low <= !shift[6];
            shift <= {shift[6:0], 1'b1};
            bit_cnt <= bit_cnt + 4'h1;
          end
        end else if (bit_cnt == 4'h8) begin
          ack_phase <= 1'b1;
          pending_low <= 1'b1;
          case (state)
            etw_pkg::ETW_CTRL: begin
              if (busy || shift[7:4] != `ETW_DEV_CODE) begin
                state <= etw_pkg::ETW_SKIP;
                pending_low <= 1'b0;
                ack_phase <= 1'b0;
              end else if (shift[`ETW_RW_BIT]) begin
                state <= etw_pkg::ETW_RDATA;
                ptr <= {shift[3:1], ptr[7:0]};
              end else begin
                state <= etw_pkg::ETW_WADDR;
                ptr <= {shift[3:1], ptr[7:0]};
              end
            end
            etw_pkg::ETW_WADDR: begin
              state <= etw_pkg::ETW_WDATA;
              ptr <= etw_addr(ptr[10:8], shift);
              page_base <= etw_addr(ptr[10:8], {shift[7:4], 4'h0});
              page_vld <= '0;
            end
            etw_pkg::ETW_WDATA: begin
              page[ptr[3:0]] <= shift;
              page_vld[ptr[3:0]] <= 1'b1;
              ptr <= {ptr[10:4], ptr[3:0] + 4'h1};
              wrote <= 1'b1;
            end
            default: state <= etw_pkg::ETW_SKIP;
          endcase
        end
      end
    end
  end

  // read byte load on the ack of the control byte happens at the ack fall above;
  // first bit of a read goes out after the control ack
  ////////////////////////////////////////////////////////////////////////
  // self-timed programming cycle
  logic launch;
  assign launch = stop_det && state == etw_pkg::ETW_WDATA && wrote;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      wc_cnt <= 32'h0;
      flush_idx <= 5'h0;
    end else if (launch) begin
      busy <= 1'b1;
      wc_cnt <= 32'h0;
      flush_idx <= 5'h0;
    end else if (busy) begin
      if (flush_idx < 5'h10) begin
        flush_idx <= flush_idx + 5'h1;
      end
      if (wc_cnt == 32'(WRITE_CYC - 1)) begin
        busy <= 1'b0;
      end else begin
        wc_cnt <= wc_cnt + 32'h1;
      end
    end
  end

  // commit page into array unless protected
  always_ff @(posedge clock) begin
    if (busy && flush_idx < 5'h10 && page_vld[flush_idx[3:0]] && !wp_s[1]) begin
      mem[{page_base[10:4], flush_idx[3:0]}] <= page[flush_idx[3:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // delayed open-drain output
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dly <= 5'h0;
      drive_low <= 1'b0;
    end else if (start_det || stop_det) begin
      drive_low <= 1'b0;
      dly <= 5'h0;
    end else if (scl_fall) begin
      dly <= 5'(`ETW_TX_DELAY_CYC);
    end else if (dly != 5'h0) begin
      dly <= dly - 5'h1;
      if (dly == 5'h1) begin
        drive_low <= pending_low;
      end
    end
  end
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe_n = !drive_low;
endmodule // etw_client

// *** etw_defines.svh ***
/*
  constants for the two-wire eeprom client and its host end.
  assumes a 50 MHz system clock on both ends.
*/
`ifndef ETW_DEFINES_SVH
`define ETW_DEFINES_SVH
`define ETW_CLK_NS 20
// control code the client answers to; the value is arbitrary
`define ETW_DEV_CODE 4'h5
`define ETW_TX_DELAY_NS 300
`define ETW_TX_DELAY_CYC ((`ETW_TX_DELAY_NS + `ETW_CLK_NS - 1) / `ETW_CLK_NS)
`define ETW_WRITE_MS 5
`define ETW_WRITE_CYC ((`ETW_WRITE_MS * 1000000) / `ETW_CLK_NS)
`define ETW_PAGE_BYTES 16
`define ETW_ADDR_W 11
// clocks per quarter scl period; scl low must outlast the client's output delay plus its synchroniser
`define ETW_SCL_HALF 12
`define ETW_RW_BIT 0
`endif

// *** etw_fifo.sv ***
/*
  small flip-flop fifo with valid/ready on both sides.
  assumes one clock and active-low asynchronous reset.
*/
module etw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage and pointers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // etw_fifo

// *** etw_host.sv ***
/*
  two-wire host: makes scl by divider, frames start/stop, moves bytes.
  user side issues one byte per request; bytes pass through a fifo.
  assumes the client end shares the open-drain wires.
*/
`include "etw_defines.svh"
module etw_host (
  input wire logic clock,
  input wire logic nrst,
  etw_bus_if.host bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_data,
  input wire logic req_start,
  input wire logic req_stop,
  input wire logic req_read,
  input wire logic req_last,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [7:0] rsp_data,
  output logic rsp_ack
);
  ////////////////////////////////////////////////////////////////////////
  // request fifo: {start, stop, read, last, data}
  logic f_valid;
  logic f_ready;
  logic [11:0] f_data;
  etw_fifo #(.WIDTH(12), .DEPTH(8)) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_start, req_stop, req_read, req_last, req_data}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );
  logic [1:0] sda_s;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sda_s <= 2'h3;
    end else begin
      sda_s <= {sda_s[0], bus.sda};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // quarter-period tick and bit engine
  etw_pkg::etw_host_state_t state;
  logic [3:0] div;
  logic [1:0] ph;
  logic [3:0] bit_cnt;
  logic [8:0] sh;
  logic [8:0] rx;
  logic [11:0] cur;
  logic scl_low;
  logic sda_low;
  logic tick;
  assign tick = (div == 4'(`ETW_SCL_HALF - 1));
  assign f_ready = (state == etw_pkg::ETW_H_IDLE) && !rsp_valid;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div <= 4'h0;
    end else begin
      div <= tick ? 4'h0 : div + 4'h1;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= etw_pkg::ETW_H_IDLE;
      ph <= 2'h0;
      bit_cnt <= 4'h0;
      sh <= 9'h1ff;
      rx <= 9'h0;
      cur <= 12'h0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
    end else begin
      if (rsp_valid && rsp_ready) begin
        rsp_valid <= 1'b0;
      end
      case (state)
        etw_pkg::ETW_H_IDLE: begin
          if (f_valid && f_ready) begin
            cur <= f_data;
            ph <= 2'h0;
            bit_cnt <= 4'h0;
            // read: release data bits, ack low unless last
            sh <= f_data[9] ? {8'hff, f_data[8]} : {f_data[7:0], 1'b1};
            state <= f_data[11] ? etw_pkg::ETW_H_START : etw_pkg::ETW_H_BIT;
          end
        end
        etw_pkg::ETW_H_START: begin
          if (tick) begin
            ph <= ph + 2'h1;
            case (ph)
              // release sda while scl is still low, so a late client ack cannot make a stop
              2'h0: sda_low <= 1'b0;
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= 1'b1;
              default: begin
                scl_low <= 1'b1;
                ph <= 2'h0;
                state <= etw_pkg::ETW_H_BIT;
              end
            endcase
          end
        end
        etw_pkg::ETW_H_BIT: begin
          if (tick) begin
            ph <= ph + 2'h1;
            case (ph)
              2'h0: sda_low <= !sh[8];
              2'h1: scl_low <= 1'b0;
              2'h2: rx <= {rx[7:0], sda_s[1]};
              default: begin
                scl_low <= 1'b1;
                sh <= {sh[7:0], 1'b1};
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == 4'h8) begin
                  state <= cur[10] ? etw_pkg::ETW_H_STOP : etw_pkg::ETW_H_DONE;
                end
              end
            endcase
          end
        end
        etw_pkg::ETW_H_STOP: begin
          if (tick) begin
            ph <= ph + 2'h1;
            case (ph)
              2'h0: sda_low <= 1'b1;
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= 1'b0;
              default: begin
                ph <= 2'h0;
                state <= etw_pkg::ETW_H_DONE;
              end
            endcase
          end
        end
        etw_pkg::ETW_H_DONE: begin
          rsp_valid <= 1'b1;
          rsp_data <= rx[8:1];
          rsp_ack <= !rx[0];
          state <= etw_pkg::ETW_H_IDLE;
        end
        default: state <= etw_pkg::ETW_H_IDLE;
      endcase
    end
  end
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe_n = !scl_low;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe_n = !sda_low;
endmodule // etw_host

// *** etw_pkg.sv ***
/*
  shared types for the two-wire eeprom client and host.
  assumes etw_defines.svh is compiled alongside.
*/
package etw_pkg;
  typedef enum logic [2:0] {
    ETW_IDLE = 3'b000,
    ETW_CTRL = 3'b001,
    ETW_WADDR = 3'b010,
    ETW_WDATA = 3'b011,
    ETW_RDATA = 3'b100,
    ETW_SKIP = 3'b101
  } etw_dev_state_t;
  typedef enum logic [2:0] {
    ETW_H_IDLE = 3'b000,
    ETW_H_START = 3'b001,
    ETW_H_BIT = 3'b010,
    ETW_H_STOP = 3'b011,
    ETW_H_DONE = 3'b100
  } etw_host_state_t;
endpackage

// *** testbench.sv ***
/*
  self-checking bench: host and client joined by the bus interface.
  assumes 50 MHz clock and a shortened programming time.
*/
`include "etw_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WCYC = 1000;
  logic clock, nrst, write_protect, busy, hit;
  logic req_valid, req_ready, req_start, req_stop, req_read, req_last, rsp_valid, rsp_ack;
  logic [7:0] req_data, rsp_data;
  logic [31:0] lfsr = 32'h244f;
  logic [2:0] spare = 3'h0;
  logic rsp_ready = 1'b0;
  logic saw_full = 1'b0;
  logic [7:0] mem [0:2047];
  logic [9:0] expq [$];
  logic [9:0] e;
  int bad_count, checks, cyc, brun;
  etw_bus_if u_etw_bus_if ();
  etw_host u_etw_host (.clock(clock), .nrst(nrst), .bus(u_etw_bus_if), .req_valid(req_valid),
    .req_ready(req_ready), .req_data(req_data), .req_start(req_start), .req_stop(req_stop),
    .req_read(req_read), .req_last(req_last), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  etw_client #(.WRITE_CYC(WCYC)) u_etw_client (.clock(clock), .nrst(nrst), .bus(u_etw_bus_if),
    .write_protect(write_protect), .spare_address_pin_0(spare[0]), .spare_address_pin_1(spare[1]),
    .spare_address_pin_2(spare[2]), .busy(busy));
  etw_bus_asserts u_etw_bus_asserts (.clock(clock), .nrst(nrst), .scl(u_etw_bus_if.scl),
    .sda(u_etw_bus_if.sda), .dev_sda_o(u_etw_bus_if.dev_sda_o), .dev_sda_oe_n(u_etw_bus_if.dev_sda_oe_n));
  //////////////////////////////////////////////////
  function logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function logic [7:0] ctrl(input logic [10:0] a, input logic r);
    return {`ETW_DEV_CODE, a[10:8], r};
  endfunction
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // hold one request until taken, note its expected answer
  task send(input logic [7:0] d, input logic st, sp, rd, ls, input logic [9:0] ex);
    int n;
    req_valid <= 1'b1;
    req_data <= d;
    req_start <= st;
    req_stop <= sp;
    req_read <= rd;
    req_last <= ls;
    n = 0;
    @(negedge clock);
    while (req_ready !== 1'b1 && n < 5000) begin
      saw_full = 1'b1;
      n++;
      @(negedge clock);
    end
    @(posedge clock);
    expq.push_back(ex);
  endtask
  task wr(input logic [7:0] d, input logic st, sp, ak);
    send(d, st, sp, 1'b0, 1'b0, {1'b0, ak, 8'h00});
  endtask
  task drain;
    int n;
    n = 0;
    while (expq.size() != 0 && n < 20000) begin
      @(posedge clock);
      n++;
    end
  endtask
  task wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    @(negedge clock);
    while (busy !== v && n < lim) begin
      @(negedge clock);
      n++;
    end
    hit = (busy === v);
    @(posedge clock);
  endtask
  // page write of n random bytes, model updated when keep
  task page(input logic [10:0] a, input int n, input logic keep);
    logic [7:0] d;
    wr(ctrl(a, 1'b0), 1'b1, 1'b0, 1'b1);
    wr(a[7:0], 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      d = lfsr[15:8];
      if (keep) mem[{a[10:4], 4'(a[3:0] + i)}] = d;
      wr(d, 1'b0, i == n - 1, 1'b1);
    end
    req_valid <= 1'b0;
    drain();
  endtask
  // random read of sixteen bytes, nack on the last
  task rdp(input logic [10:0] a);
    wr(ctrl(a, 1'b0), 1'b1, 1'b0, 1'b1);
    wr(a[7:0], 1'b0, 1'b0, 1'b1);
    wr(ctrl(a, 1'b1), 1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 16; i++) begin
      send(8'h00, 1'b0, i == 15, 1'b1, i == 15, {1'b1, i != 15, mem[a + 11'(i)]});
    end
    req_valid <= 1'b0;
    drain();
  endtask
  //////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // random stall on responses, spare pins toggled at random
  always @(posedge clock) begin
    lfsr <= lfsr_next(lfsr);
    spare <= lfsr[2:0];
    rsp_ready <= lfsr[3] | lfsr[4];
  end
  // response scoreboard
  always @(negedge clock) begin
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      e = (expq.size() != 0) ? expq.pop_front() : 10'h3ff;
      check({7'h00, rsp_ack}, {7'h00, e[8]});
      if (e[9]) check(rsp_data, e[7:0]);
    end
  end
  // programming time and hang limit
  always @(posedge clock) begin
    cyc++;
    if (busy === 1'b1) brun++;
    else if (brun != 0) begin
      check({7'h00, brun <= WCYC + 4}, 8'h01);
      brun = 0;
    end
    if (cyc == 90000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    nrst = 1'b0;
    write_protect = 1'b0;
    req_valid = 1'b0;
    req_data = 8'h00;
    req_start = 1'b0;
    req_stop = 1'b0;
    req_read = 1'b0;
    req_last = 1'b0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    page(11'h22e, 18, 1'b1);
    wait_busy(1'b1, 300);
    check({7'h00, hit}, 8'h01);
    wr(ctrl(11'h22e, 1'b0), 1'b1, 1'b1, 1'b0);
    req_valid <= 1'b0;
    drain();
    wait_busy(1'b0, 5000);
    rdp(11'h220);
    write_protect <= 1'b1;
    page(11'h224, 4, 1'b0);
    wait_busy(1'b1, 300);
    wait_busy(1'b0, 5000);
    write_protect <= 1'b0;
    rdp(11'h220);
    for (int c = 0; c < 16; c++) begin
      if (4'(c) != `ETW_DEV_CODE) begin
        wr({4'(c), 3'h1, 1'b0}, 1'b1, 1'b1, 1'b0);
        req_valid <= 1'b0;
        drain();
      end
    end
    check({7'h00, saw_full}, 8'h01);
    check(8'(expq.size()), 8'h00);
    finish_test();
  end
endmodule // testbench
